/* logic/arsc_device.sv */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "arsc_params.svh"
// Contract
// [R1] Result readable once done flag is set
// [R2] Single-ended code is unsigned Vin*1024/Vref
// [R3] Single-ended clamps to 0x000 and 0x3FF
// [R4] Differential code two's complement, 0x200..0x1FF
// [R5] Bit nine carries differential sign
// [R6] Differential saturates at 0x1FF
// [R7] Reference from supply, bandgap or pin
// [R8] No internal reference with external drive
// [R9] Discard first result after reference change
// [R10] Before sleep: enabled, idle, single, irq on
// [R11] Sleep entry starts conversion once halted
// [R12] Completion irq wakes or still raised later
// [R13] No further auto conversion until resleep
// [R14] Other sleep modes keep converter enabled
// [R15] Toggle enable after deep sleep before diff
// [R16] Port outputs stay quiet during conversion
// [R17] Software subtracts self-measured offset residue
// [R18] Left-justify select picks byte layout
// [R19] Layout changes immediately on select change
// [R20] Disable aborts a running conversion
// [R21] Left layout: bits 9..2 high, 1..0 top
// [R22] Right layout: bits 7..0 low, 9..8 high
module arsc_device import arsc_pkg::*; #(
  parameter int CONV_CYCLES = `ARSC_CONV_CYCLES,
  parameter int FIRST_CYCLES = `ARSC_FIRST_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  arsc_if.device link,
  output logic [1:0] o_ref_active
);
  typedef struct packed {
    arsc_state_t st;
    logic [4:0] cnt;
    logic primed;
    logic slept;
    logic done;
    logic [9:0] code;
    logic [1:0] refs;
    logic diff;
  } arsc_dev_t;
  arsc_dev_t s_reg, s_next;
  logic [9:0] conv_code;
  logic sleep_go;

  arsc_code u_code (
    .i_sample(link.sample),
    .i_diff(s_reg.diff),
    .i_left(link.left_justify_select),
    .i_code_hold(s_reg.code),
    .o_code(conv_code),
    .o_low(link.result_low_byte), // [R19]
    .o_high(link.result_high_byte)
  );

  // One automatic start per sleep entry
  assign sleep_go = link.halted && link.sleep_nr && !s_reg.slept; // [R11] [R13] [R14]

  always_comb begin
    s_next = s_reg;
    if (!link.halted) s_next.slept = 1'b0; // [R13]
    if (link.done_clear) s_next.done = 1'b0;
    unique case (s_reg.st)
      ARSC_IDLE: begin
        if (s_reg.st == ARSC_IDLE && link.enable) begin
          s_next.refs = link.ref_sel; // [R7]
          s_next.diff = link.diff_mode;
        end
        if (link.enable && (link.start || sleep_go)) begin
          s_next.st = ARSC_CONV;
          s_next.cnt = s_reg.primed ? 5'(CONV_CYCLES - 1) : 5'(FIRST_CYCLES - 1);
          s_next.primed = 1'b1;
          if (sleep_go) s_next.slept = 1'b1; // [R11]
        end
      end
      ARSC_CONV: begin
        if (s_reg.cnt != 5'h00) begin
          s_next.cnt = s_reg.cnt - 5'h01;
        end else if (link.enable) begin
          // A disable on the last cycle still aborts: no code, no flag
          s_next.code = conv_code; // [R1]
          s_next.done = 1'b1; // [R1] [R12]
          s_next.st = ARSC_IDLE;
        end
      end
      default: s_next.st = ARSC_IDLE;
    endcase
    if (!link.enable) begin
      s_next.st = ARSC_IDLE; // [R20]
      s_next.primed = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.busy = (s_reg.st == ARSC_CONV);
  assign link.conversion_done_flag = s_reg.done;
  assign link.irq = s_reg.done; // [R12]
  assign o_ref_active = s_reg.refs;
endmodule // arsc_device
`default_nettype wire

/* inc/arsc_params.svh */
`ifndef ARSC_PARAMS_SVH
`define ARSC_PARAMS_SVH
// Register offsets of the controller (byte addresses on APB)
`define ARSC_OFF_CTRL 12'h000
`define ARSC_OFF_SEL 12'h004
`define ARSC_OFF_STAT 12'h008
`define ARSC_OFF_RES 12'h00c
`define ARSC_OFF_SAMPLE 12'h010
// Control register fields
`define ARSC_CTRL_EN 0
`define ARSC_CTRL_START 1
`define ARSC_CTRL_DONE_IE 2
`define ARSC_CTRL_SLEEP 3
`define ARSC_CTRL_SLEEP_NR 4
// Selection register fields
`define ARSC_SEL_LJ 5
`define ARSC_SEL_REF_LO 6
`define ARSC_SEL_DIFF 8
// Reset values
`define ARSC_CTRL_RST 8'h00
`define ARSC_SEL_RST 8'h00
// Code limits
`define ARSC_SE_MAX 10'h3ff
`define ARSC_DIFF_MAX 10'h1ff
`define ARSC_DIFF_MIN 10'h200
// Conversion time in link cycles
`define ARSC_CONV_CYCLES 13
`define ARSC_FIRST_CYCLES 25
`endif

/* inc/arsc_pkg.sv */
package arsc_pkg;
  typedef enum logic [1:0] {ARSC_REF_EXT, ARSC_REF_SUPPLY, ARSC_REF_RSVD, ARSC_REF_BANDGAP} arsc_ref_t;
  typedef enum logic [1:0] {ARSC_IDLE, ARSC_CONV, ARSC_DONE} arsc_state_t;
endpackage

/* inc/arsc_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface arsc_if;
  logic enable;
  logic start;
  logic halted;
  logic sleep_nr;
  logic left_justify_select;
  logic diff_mode;
  logic [1:0] ref_sel;
  logic signed [11:0] sample;
  logic busy;
  logic conversion_done_flag;
  logic done_clear;
  logic irq;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;
  modport device (input enable, start, halted, sleep_nr, left_justify_select, diff_mode,
    ref_sel, sample, done_clear, output busy, conversion_done_flag, irq,
    result_low_byte, result_high_byte);
  modport host (output enable, start, halted, sleep_nr, left_justify_select, diff_mode,
    ref_sel, sample, done_clear, input busy, conversion_done_flag, irq,
    result_low_byte, result_high_byte);
endinterface
`default_nettype wire

/* logic/arsc_code.sv */
`timescale 1ns/1ns
`default_nettype none
`include "arsc_params.svh"
// Turns a signed sample into a 10-bit code and lays the held code across two bytes
module arsc_code import arsc_pkg::*; (
  input wire logic signed [11:0] i_sample,
  input wire logic i_diff,
  input wire logic i_left,
  input wire logic [9:0] i_code_hold,
  output logic [9:0] o_code,
  output logic [7:0] o_low,
  output logic [7:0] o_high
);
  always_comb begin
    if (i_diff) begin
      if (i_sample > 12'sd511) o_code = `ARSC_DIFF_MAX; // [R6]
      else if (i_sample < -12'sd512) o_code = `ARSC_DIFF_MIN; // [R4]
      else o_code = i_sample[9:0]; // [R4] [R5] [R6]
    end else begin
      if (i_sample < 12'sd0) o_code = 10'h000; // [R3]
      else if (i_sample > 12'sd1023) o_code = `ARSC_SE_MAX; // [R3]
      else o_code = i_sample[9:0]; // [R2]
    end
  end
  always_comb begin
    if (i_left) begin
      o_high = i_code_hold[9:2]; // [R18] [R21]
      o_low = {i_code_hold[1:0], 6'h00}; // [R21]
    end else begin
      o_high = {6'h00, i_code_hold[9:8]}; // [R22]
      o_low = i_code_hold[7:0]; // [R22]
    end
  end
endmodule // arsc_code
`default_nettype wire

/* logic/arsc_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "arsc_params.svh"
// Processor-side controller: APB registers drive the converter link
module arsc_host import arsc_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_wake,
  arsc_if.host link
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [9:0] sel;
    logic signed [11:0] sample;
    logic start;
    logic clr;
  } arsc_host_t;
  arsc_host_t s_reg, s_next;
  logic wr, rd, hit;

  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && !i_pwrite;
  assign hit = (i_paddr == `ARSC_OFF_CTRL) || (i_paddr == `ARSC_OFF_SEL)
    || (i_paddr == `ARSC_OFF_STAT) || (i_paddr == `ARSC_OFF_RES)
    || (i_paddr == `ARSC_OFF_SAMPLE);

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.clr = 1'b0;
    if (wr) begin
      unique case (i_paddr)
        `ARSC_OFF_CTRL: begin
          s_next.ctrl = i_pwdata[7:0];
          s_next.ctrl[`ARSC_CTRL_START] = 1'b0;
          s_next.start = i_pwdata[`ARSC_CTRL_START];
        end
        `ARSC_OFF_SEL: s_next.sel = i_pwdata[9:0]; // [R8] [R9] [R17]
        `ARSC_OFF_STAT: s_next.clr = i_pwdata[0];
        `ARSC_OFF_SAMPLE: s_next.sample = i_pwdata[11:0];
        default: s_next.clr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (rd) begin
      if (i_paddr == `ARSC_OFF_CTRL) o_prdata = {24'h000000, s_reg.ctrl};
      else if (i_paddr == `ARSC_OFF_SEL) o_prdata = {22'h0, s_reg.sel};
      else if (i_paddr == `ARSC_OFF_STAT) o_prdata = {30'h0, link.busy, link.conversion_done_flag};
      else if (i_paddr == `ARSC_OFF_RES) o_prdata = {16'h0000, link.result_high_byte, link.result_low_byte};
      else if (i_paddr == `ARSC_OFF_SAMPLE) o_prdata = {20'h00000, s_reg.sample};
    end
  end
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;

  assign link.enable = s_reg.ctrl[`ARSC_CTRL_EN];
  assign link.start = s_reg.start;
  // Halt follows the sleep bit alone; noise-reduction sleep also needs irq on
  assign link.halted = s_reg.ctrl[`ARSC_CTRL_SLEEP]; // [R10] [R14]
  assign link.sleep_nr = s_reg.ctrl[`ARSC_CTRL_SLEEP_NR] && s_reg.ctrl[`ARSC_CTRL_DONE_IE];
  assign link.left_justify_select = s_reg.sel[`ARSC_SEL_LJ];
  assign link.ref_sel = s_reg.sel[`ARSC_SEL_REF_LO +: 2];
  assign link.diff_mode = s_reg.sel[`ARSC_SEL_DIFF];
  assign link.sample = s_reg.sample;
  assign link.done_clear = s_reg.clr;
  assign o_wake = link.irq && s_reg.ctrl[`ARSC_CTRL_DONE_IE]; // [R12]
endmodule // arsc_host
`default_nettype wire

/* dv/arsc_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "arsc_params.svh"
module arsc_chk #(parameter int FIRST_CYCLES = `ARSC_FIRST_CYCLES) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_start,
  input wire logic i_halted,
  input wire logic i_busy,
  input wire logic i_conversion_done_flag,
  input wire logic i_done_clear,
  input wire logic i_irq,
  input wire logic i_left_justify_select,
  input wire logic [7:0] i_result_low_byte,
  input wire logic [7:0] i_result_high_byte
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_irq_flag: assert property (i_irq == i_conversion_done_flag)
    else $error("irq differs");
  a_conv_bound: assert property (i_busy |-> ##[0:FIRST_CYCLES] !i_busy)
    else $error("busy hangs");
  a_done_end: assert property ($fell(i_busy) && i_enable |-> i_conversion_done_flag)
    else $error("no flag at end");
  a_flag_hold: assert property (i_conversion_done_flag && !i_done_clear
    |=> i_conversion_done_flag) else $error("flag lost");
  a_abort_conv: assert property (i_busy && !i_enable
    |=> !i_busy && !$rose(i_conversion_done_flag)) else $error("abort failed");
  a_start_conv: assert property (i_enable && i_start && !i_busy
    && !i_conversion_done_flag |=> i_busy) else $error("start ignored");
  a_busy_cause: assert property ($rose(i_busy) |-> $past(i_start) || $past(i_halted))
    else $error("busy uncaused");
  a_no_resleep: assert property (i_halted && i_conversion_done_flag && !i_busy
    |=> !i_busy) else $error("second auto start");
  a_left_zero: assert property (i_left_justify_select
    |-> i_result_low_byte[5:0] == 6'h00) else $error("left low bits set");
  a_right_zero: assert property (!i_left_justify_select
    |-> i_result_high_byte[7:2] == 6'h00) else $error("right high bits set");
  c_done: cover property ($fell(i_busy) && i_conversion_done_flag);
  c_abort: cover property (i_busy && !i_enable);
  c_sleep: cover property (i_halted && $rose(i_busy));
endmodule // arsc_chk
`default_nettype wire

/* dv/arsc_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "arsc_params.svh"
module arsc_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, wake, d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ref_act, r;
  logic [9:0] c;
  logic [32:0] m, exp_q[$], msk_q[$];
  int failures, n_checks, seed, s;
  int tbl[10] = '{-5, -600, 0, -1, 1023, 0, 2000, 511, 517, -400};
  arsc_if lnk();
  arsc_device u_arsc_device (.i_ref_clk(clk), .i_sys_rst(rst), .link(lnk.device),
    .o_ref_active(ref_act));
  arsc_host u_arsc_host (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_wake(wake), .link(lnk.host));
  arsc_chk #(.FIRST_CYCLES(`ARSC_FIRST_CYCLES)) u_arsc_chk (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_enable(lnk.enable), .i_start(lnk.start), .i_halted(lnk.halted), .i_busy(lnk.busy),
    .i_conversion_done_flag(lnk.conversion_done_flag), .i_done_clear(lnk.done_clear),
    .i_irq(lnk.irq), .i_left_justify_select(lnk.left_justify_select),
    .i_result_low_byte(lnk.result_low_byte), .i_result_high_byte(lnk.result_high_byte));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input logic [32:0] sv, ev, input string n);
    n_checks++;
    if (sv !== ev) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, ev, sv);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e, k);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(k);
    end
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_done;
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, `ARSC_OFF_STAT, 32'h0, 33'h0, 33'h0);
      if (rd[0] === 1'b1) break;
    end
    check({32'h0, rd[0]}, 33'h1, "done flag");
  endtask
  function automatic logic [9:0] code(input int v, input logic df);
    if (df) return (v > 511) ? 10'h1ff : (v < -512) ? 10'h200 : v[9:0];
    return (v > 1023) ? 10'h3ff : (v < 0) ? 10'h000 : v[9:0];
  endfunction
  // Each completed read is compared with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      m = msk_q.pop_front();
      check({pslverr, prdata} & m, exp_q.pop_front(), "read");
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    seed = 40683;
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      s = (i < 10) ? tbl[i] : $random(seed) % 1200;
      d = i[0];
      r = (i % 3 == 2) ? 2'd3 : 2'(i % 3);
      c = code(s, d);
      apb(1'b1, `ARSC_OFF_SEL, {23'h0, d, r, 6'h00}, 33'h0, 33'h0);
      // Input is only changed while no conversion runs
      apb(1'b1, `ARSC_OFF_SAMPLE, s, 33'h0, 33'h0);
      apb(1'b1, `ARSC_OFF_CTRL, 32'h3, 33'h0, 33'h0);
      apb(1'b0, `ARSC_OFF_STAT, 32'h0, 33'h2, 33'h3);
      wait_done;
      apb(1'b0, `ARSC_OFF_RES, 32'h0, {23'h0, c}, 33'h0ffffffff);
      apb(1'b1, `ARSC_OFF_SEL, {23'h0, d, r, 6'h20}, 33'h0, 33'h0);
      apb(1'b0, `ARSC_OFF_RES, 32'h0, {17'h0, c, 6'h00}, 33'h0ffffffff);
      check({31'h0, ref_act}, {31'h0, r}, "reference");
      apb(1'b1, `ARSC_OFF_STAT, 32'h1, 33'h0, 33'h0);
    end
    apb(1'b1, `ARSC_OFF_CTRL, 32'h3, 33'h0, 33'h0);
    // Disable mid-conversion; the re-enable below forces an extended conversion
    apb(1'b1, `ARSC_OFF_CTRL, 32'h0, 33'h0, 33'h0);
    repeat (40) @(posedge clk);
    apb(1'b0, `ARSC_OFF_STAT, 32'h0, 33'h0, 33'h3);
    apb(1'b1, `ARSC_OFF_CTRL, 32'h1d, 33'h0, 33'h0);
    apb(1'b0, `ARSC_OFF_STAT, 32'h0, 33'h2, 33'h3);
    wait_done;
    check({32'h0, wake}, 33'h1, "wake");
    apb(1'b1, `ARSC_OFF_STAT, 32'h1, 33'h0, 33'h0);
    repeat (40) @(posedge clk);
    apb(1'b0, `ARSC_OFF_STAT, 32'h0, 33'h0, 33'h3);
    check({32'h0, wake}, 33'h0, "wake idle");
    apb(1'b1, `ARSC_OFF_CTRL, 32'h1, 33'h0, 33'h0);
    apb(1'b0, 12'h020, 32'h0, 33'h100000000, 33'h100000000);
    report_and_stop;
  end
endmodule // arsc_tb
`default_nettype wire
